/* core/adcrb_bank.v */
// Purpose: APB-reached configuration register bank of an eight-channel simultaneous-sampling ADC.
// Assumes: One clock MCLK at 10 MHz, synchronous active-low NRST, clock enable CE.
// Notes: Decoded controls leave the block as plain level outputs for the analog and data-port logic.
//
// Overview of operation
// - Boost bits 2-1 choose pair: 0=ch1/8, 1=ch2/7, 2=ch3/6, 3=ch4/5.
// - Boost bit 0 set turns speed-boost mode on; clear is normal operation.
// - Averaging register bit 7 is one part of the simple averaging setting.
// - Bits 9-2 give per-channel bandwidth, lsb channel 1; 1 means wide bandwidth.
// - Power-down bits 1-0: none, channels 5-8, channels 1-4, or all off.
// - Reference bit 11 set disables internal reference; external reference pin used.
// - Bit 9 selects four lanes (D3-D0) or two lanes (D3, D1).
// - Bit 8 clear gives double data rate, set gives single data rate.
// - Every register resets to all zeros, boost register included.
`timescale 1ns/1ns
`default_nettype none
`include "adcrb_defines.vh"

module adcrb_bank (
	input wire MCLK,
	input wire NRST,
	input wire CE,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	output wire [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	output wire BOOST_ON,
	output wire [1:0] FAST_PAIR_SELECT,
	output wire [7:0] BOOST_CH_MASK,
	output wire AVERAGING_SETTING_BIT,
	output wire INIT_DONE,
	output wire [7:0] CHANNEL_BANDWIDTH_SELECT,
	output wire [1:0] CHANNEL_GROUP_POWERDOWN,
	output wire [7:0] CH_ACTIVE,
	output wire INTERNAL_REFERENCE_OFF,
	output wire INTERNAL_REF_ON,
	output wire TWO_LANE_MODE,
	output wire [3:0] LANE_ENABLE,
	output wire SINGLE_DATA_RATE
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.

	wire [7:0] idx;
	wire [4:0] hit;
	wire mapped;
	wire acc;
	wire [15:0] regq [0:4];
	reg [31:0] prdata_r;
	reg [31:0] prdata_nxt;
	reg pslverr_r;

	// The word index is the byte address divided by four.
	assign idx = PADDR[9:2];

	// One hit line per register; the low address bits and upper bits must be zero.
	assign hit[0] = (idx == `ADCRB_IDX_BOOST);
	assign hit[1] = (idx == `ADCRB_IDX_AVG);
	assign hit[2] = (idx == `ADCRB_IDX_INIT);
	assign hit[3] = (idx == `ADCRB_IDX_BWPD);
	assign hit[4] = (idx == `ADCRB_IDX_REFFMT);
	assign mapped = (|hit) && (PADDR[1:0] == 2'h0) && (PADDR[11:10] == 2'h0);

	// Access phase of a transfer; the slave answers without wait states.
	assign acc = PSEL && PENABLE && CE;
	assign PREADY = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// Register storage.

	// Each register is a plain sixteen-bit store with byte lanes.
	genvar g;
	generate
		for (g = 0; g < `ADCRB_NREG; g = g + 1) begin : gen_reg
			adcrb_reg u_reg (
				.clk(MCLK),
				.nrst(NRST),
				.ce(CE),
				.we(acc && PWRITE && hit[g] && mapped),
				.strb(PSTRB[1:0]),
				.wdata(PWDATA[15:0]),
				.q(regq[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Read path.

	// Select the addressed register; upper bits and unmapped reads return zero.
	always @* begin
		prdata_nxt = 32'h00000000;
		if (mapped) begin
			case (1'b1)
				hit[0]: prdata_nxt = {16'h0000, regq[0]};
				hit[1]: prdata_nxt = {16'h0000, regq[1]};
				hit[2]: prdata_nxt = {16'h0000, regq[2]};
				hit[3]: prdata_nxt = {16'h0000, regq[3]};
				hit[4]: prdata_nxt = {16'h0000, regq[4]};
				default: prdata_nxt = 32'h00000000;
			endcase
		end
	end

	// Read data and error are registered in the setup phase so they stand through the access phase.
	always @(posedge MCLK) begin
		if (!NRST) begin
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (CE) begin
			if (PSEL && !PENABLE) begin
				prdata_r <= PWRITE ? 32'h00000000 : prdata_nxt;
				pslverr_r <= !mapped;
			end
		end
	end

	assign PRDATA = prdata_r;
	assign PSLVERR = pslverr_r && PSEL && PENABLE;

	////////////////////////////////////////////////////////////////////////////////
	// Speed boost and averaging controls.

	reg [7:0] boost_mask_r;

	assign BOOST_ON = regq[0][`ADCRB_BOOST_EN_BIT];
	assign FAST_PAIR_SELECT = regq[0][`ADCRB_PAIR_MSB:`ADCRB_PAIR_LSB];

	// Decode the boosted channel pair, zero when boost is off; bit 0 is channel 1.
	always @(posedge MCLK) begin
		if (!NRST) begin
			boost_mask_r <= 8'h00;
		end else if (CE) begin
			if (!regq[0][`ADCRB_BOOST_EN_BIT]) begin
				boost_mask_r <= 8'h00;
			end else begin
				case (regq[0][`ADCRB_PAIR_MSB:`ADCRB_PAIR_LSB])
					2'h0: boost_mask_r <= 8'h81;
					2'h1: boost_mask_r <= 8'h42;
					2'h2: boost_mask_r <= 8'h24;
					2'h3: boost_mask_r <= 8'h18;
					default: boost_mask_r <= 8'h00;
				endcase
			end
		end
	end

	assign BOOST_CH_MASK = boost_mask_r;
	assign AVERAGING_SETTING_BIT = regq[1][`ADCRB_AVG_BIT];

	// The device runs normally only once the host has set the init bit.
	assign INIT_DONE = regq[2][`ADCRB_INIT_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Bandwidth and power-down.

	reg [7:0] ch_active_r;

	assign CHANNEL_BANDWIDTH_SELECT = regq[3][`ADCRB_BW_MSB:`ADCRB_BW_LSB];
	assign CHANNEL_GROUP_POWERDOWN = regq[3][`ADCRB_PD_MSB:`ADCRB_PD_LSB];

	// Channel activity from the power-down code; bit 0 is channel 1.
	always @(posedge MCLK) begin
		if (!NRST) begin
			ch_active_r <= 8'hFF;
		end else if (CE) begin
			case (regq[3][`ADCRB_PD_MSB:`ADCRB_PD_LSB])
				`ADCRB_PD_NONE: ch_active_r <= 8'hFF;
				`ADCRB_PD_HIGH: ch_active_r <= 8'h0F;
				`ADCRB_PD_LOW: ch_active_r <= 8'hF0;
				`ADCRB_PD_ALL: ch_active_r <= 8'h00;
				default: ch_active_r <= 8'h00;
			endcase
		end
	end

	assign CH_ACTIVE = ch_active_r;

	////////////////////////////////////////////////////////////////////////////////
	// Reference and output format.

	reg [3:0] lane_en_r;

	assign INTERNAL_REFERENCE_OFF = regq[4][`ADCRB_REFOFF_BIT];
	assign INTERNAL_REF_ON = !regq[4][`ADCRB_REFOFF_BIT];
	assign TWO_LANE_MODE = regq[4][`ADCRB_LANES_BIT];
	assign SINGLE_DATA_RATE = regq[4][`ADCRB_RATE_BIT];

	// Lane enables, bit n is lane Dn: four lanes use all, two lanes only D3 and D1.
	always @(posedge MCLK) begin
		if (!NRST) begin
			lane_en_r <= 4'hF;
		end else if (CE) begin
			lane_en_r <= regq[4][`ADCRB_LANES_BIT] ? 4'hA : 4'hF;
		end
	end

	assign LANE_ENABLE = lane_en_r;

endmodule // adcrb_bank

`default_nettype wire

/* core/adcrb_reg.v */
// Purpose: One sixteen-bit configuration register with write strobe and byte lanes.
// Assumes: Synchronous active-low reset and a clock enable that freezes the register.
// Notes: Reset value comes from the header.
`timescale 1ns/1ns
`default_nettype none
`include "adcrb_defines.vh"

module adcrb_reg (
	input wire clk,
	input wire nrst,
	input wire ce,
	input wire we,
	input wire [1:0] strb,
	input wire [15:0] wdata,
	output wire [15:0] q
);

	reg [15:0] q_r;
	reg [15:0] q_nxt;

	// Merge the enabled byte lanes of the write into the held value.
	always @* begin
		q_nxt = q_r;
		if (we) begin
			if (strb[0]) begin
				q_nxt[7:0] = wdata[7:0];
			end
			if (strb[1]) begin
				q_nxt[15:8] = wdata[15:8];
			end
		end
	end

	// Hold the value; reset clears every bit.
	always @(posedge clk) begin
		if (!nrst) begin
			q_r <= `ADCRB_RST;
		end else if (ce) begin
			q_r <= q_nxt;
		end
	end

	assign q = q_r;

endmodule // adcrb_reg

`default_nettype wire

/* include/adcrb_defines.vh */
// Purpose: Offsets, field positions, reset values and bus constants of the ADC configuration register bank.
// Assumes: APB with 32-bit data, one register per aligned word, registers sixteen bits wide.
// Notes: Printed offsets are register indices; the byte address is four times the index.
`ifndef ADCRB_DEFINES_VH
`define ADCRB_DEFINES_VH

// Register indices as printed.
`define ADCRB_IDX_BOOST 8'h37
`define ADCRB_IDX_AVG 8'h3C
`define ADCRB_IDX_INIT 8'h92
`define ADCRB_IDX_BWPD 8'hC0
`define ADCRB_IDX_REFFMT 8'hC1

// Number of registers and the width of each.
`define ADCRB_NREG 5
`define ADCRB_RW 16

// Common reset value of every register.
`define ADCRB_RST 16'h0000

// Field positions in the speed boost register.
`define ADCRB_BOOST_EN_BIT 0
`define ADCRB_PAIR_LSB 1
`define ADCRB_PAIR_MSB 2

// Field position in the averaging register.
`define ADCRB_AVG_BIT 7

// Field position in the initialization register.
`define ADCRB_INIT_BIT 1

// Field positions in the bandwidth and power-down register.
`define ADCRB_PD_LSB 0
`define ADCRB_PD_MSB 1
`define ADCRB_BW_LSB 2
`define ADCRB_BW_MSB 9

// Field positions in the reference and output format register.
`define ADCRB_RATE_BIT 8
`define ADCRB_LANES_BIT 9
`define ADCRB_REFOFF_BIT 11

// Power-down codes.
`define ADCRB_PD_NONE 2'h0
`define ADCRB_PD_HIGH 2'h1
`define ADCRB_PD_LOW 2'h2
`define ADCRB_PD_ALL 2'h3

`endif

/* sim/adcrb_bank_sva.sv */
// Purpose: Port assertions for the register bank.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to the bank below.
`timescale 1ns/1ns
`default_nettype none
module adcrb_sva (
	input wire MCLK,
	input wire NRST,
	input wire CE,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	input wire PREADY,
	input wire PSLVERR,
	input wire BOOST_ON,
	input wire [1:0] FAST_PAIR_SELECT,
	input wire [7:0] BOOST_CH_MASK,
	input wire INIT_DONE,
	input wire [1:0] CHANNEL_GROUP_POWERDOWN,
	input wire [7:0] CH_ACTIVE,
	input wire INTERNAL_REFERENCE_OFF,
	input wire INTERNAL_REF_ON,
	input wire TWO_LANE_MODE,
	input wire [3:0] LANE_ENABLE
);
////////////////////////////////////////////////////////////
// Access phase that the bank may act on.
wire acc = PSEL && PENABLE && CE;
default clocking @(posedge MCLK); endclocking
default disable iff (!NRST);
chk_ready_high: assert property (PREADY) else $error("ready low");
chk_err_map: assert property (acc |-> PSLVERR == !(PADDR inside {12'h0DC, 12'h0F0, 12'h248, 12'h300, 12'h304}))
	else $error("error flag wrong");
chk_boost_write: assert property (acc && PWRITE && PADDR == 12'h0DC && PSTRB[0]
	|=> BOOST_ON == $past(PWDATA[0]) && FAST_PAIR_SELECT == $past(PWDATA[2:1])) else $error("boost write lost");
chk_pair_mask: assert property (CE |=> BOOST_CH_MASK == ($past(BOOST_ON) ?
	(8'h01 << $past(FAST_PAIR_SELECT)) | (8'h80 >> $past(FAST_PAIR_SELECT)) : 8'h00)) else $error("pair mask wrong");
chk_group_off: assert property (CE |=> CH_ACTIVE == {{4{~$past(CHANNEL_GROUP_POWERDOWN[0])}},
	{4{~$past(CHANNEL_GROUP_POWERDOWN[1])}}}) else $error("active channels wrong");
chk_lane_count: assert property (CE |=> LANE_ENABLE == ($past(TWO_LANE_MODE) ? 4'hA : 4'hF))
	else $error("lanes wrong");
chk_ref_pair: assert property (INTERNAL_REF_ON != INTERNAL_REFERENCE_OFF) else $error("reference pair");
chk_frozen_hold: assert property (!CE |=> $stable(INIT_DONE) && $stable(BOOST_ON)) else $error("moved while frozen");
endmodule // adcrb_sva
bind adcrb_bank adcrb_sva u_sva (.MCLK(MCLK), .NRST(NRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PSLVERR(PSLVERR), .BOOST_ON(BOOST_ON),
	.FAST_PAIR_SELECT(FAST_PAIR_SELECT), .BOOST_CH_MASK(BOOST_CH_MASK), .INIT_DONE(INIT_DONE),
	.CHANNEL_GROUP_POWERDOWN(CHANNEL_GROUP_POWERDOWN), .CH_ACTIVE(CH_ACTIVE), .TWO_LANE_MODE(TWO_LANE_MODE),
	.INTERNAL_REFERENCE_OFF(INTERNAL_REFERENCE_OFF), .INTERNAL_REF_ON(INTERNAL_REF_ON), .LANE_ENABLE(LANE_ENABLE));
`default_nettype wire

/* sim/adcrb_bank_test.sv */
// Purpose: Self-checking bench of the register bank.
// Assumes: APB master waits on pready with a bound.
// Notes: A model array mirrors the registers.
`timescale 1ns/1ns
`default_nettype none
module adcrb_bank_test;
	logic clk = 0, nrst = 0, ce = 1, sel = 0, en = 0, we = 0;
	logic [11:0] adr = 0;
	logic [31:0] wd = 0, rdat, r, x = 71;
	logic [3:0] stb = 0, le;
	logic [1:0] fps, cgp;
	logic [7:0] bm, cbw, cha;
	logic rdy, err, bon, avb, idn, rof, ron, two, sdr, e1;
	logic [15:0] mdl[5] = '{default: 0};
	logic [11:0] ad[5] = '{12'h0DC, 12'h0F0, 12'h248, 12'h300, 12'h304};
	logic [15:0] msk[5] = '{16'h0007, 16'h0080, 16'h0002, 16'h03FF, 16'h0B00};
	int failures = 0, n_compared = 0, i, j;
	adcrb_bank i_dut (.MCLK(clk), .NRST(nrst), .CE(ce), .PSEL(sel), .PENABLE(en), .PWRITE(we), .PADDR(adr),
		.PWDATA(wd), .PSTRB(stb), .PRDATA(rdat), .PREADY(rdy), .PSLVERR(err), .BOOST_ON(bon),
		.FAST_PAIR_SELECT(fps), .BOOST_CH_MASK(bm), .AVERAGING_SETTING_BIT(avb), .INIT_DONE(idn),
		.CHANNEL_BANDWIDTH_SELECT(cbw), .CHANNEL_GROUP_POWERDOWN(cgp), .CH_ACTIVE(cha),
		.INTERNAL_REFERENCE_OFF(rof), .INTERNAL_REF_ON(ron), .TWO_LANE_MODE(two), .LANE_ENABLE(le),
		.SINGLE_DATA_RATE(sdr));
	// Free-running bus clock.
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////
	// Xorshift source for data and register choice.
	function logic [31:0] nxt;
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task chk(input string n, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task tally_and_finish;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One APB transfer; read data and error are taken at the pready edge.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge clk);
		sel <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		stb <= s;
		@(posedge clk);
		en <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rdy !== 1'b1 && k < 50);
		if (rdy !== 1'b1) begin
			failures++;
			tally_and_finish;
		end
		r = rdat;
		e1 = err;
		sel <= 0;
		en <= 0;
	endtask
	task wr(input int n, input logic [15:0] d, input logic [3:0] s);
		if (s[0]) mdl[n][7:0] = d[7:0];
		if (s[1]) mdl[n][15:8] = d[15:8];
		apb(1, ad[n], {16'h0, d}, s);
	endtask
	task rd(input int n);
		apb(0, ad[n], 0, 0);
		chk("reg", r, {16'h0, mdl[n]});
	endtask
	// Decoded outputs against the model, sampled away from the edge.
	task outs;
		logic [1:0] p, q;
		p = mdl[0][2:1];
		q = mdl[3][1:0];
		// Decoded outputs are registered one edge after the field, so let that edge pass first.
		@(posedge clk);
		@(negedge clk);
		chk("boost", bon, mdl[0][0]);
		chk("pair", fps, p);
		chk("mask", bm, mdl[0][0] ? (8'h01 << p) | (8'h80 >> p) : 8'h00);
		chk("avg", avb, mdl[1][7]);
		chk("init", idn, mdl[2][1]);
		chk("bw", cbw, mdl[3][9:2]);
		chk("pd", cgp, q);
		chk("act", cha, {{4{~q[0]}}, {4{~q[1]}}});
		chk("ref", {rof, ron}, {mdl[4][11], ~mdl[4][11]});
		chk("lane", {two, le}, mdl[4][9] ? 5'h1A : 5'h0F);
		chk("rate", sdr, mdl[4][8]);
	endtask
	// Main sequence.
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1;
		for (i = 0; i < 5; i++) rd(i);
		outs;
		$display("reset test done");
		for (j = 0; j < 4; j++) begin
			wr(0, 16'(2 * j + 1), 4'h3);
			wr(3, 16'(j), 4'h3);
			outs;
		end
		$display("code test done");
		repeat (30) begin
			i = nxt() % 5;
			wr(i, nxt() & msk[i], 4'h3);
			rd(i);
			outs;
		end
		$display("random test done");
		wr(2, 16'h0002, 4'h3);
		@(posedge clk);
		ce <= 0;
		apb(1, ad[2], 0, 4'h3);
		ce <= 1;
		rd(2);
		wr(3, 16'h03FC, 4'h1);
		rd(3);
		apb(1, 12'h0E0, 32'h0000FFFF, 4'hF);
		chk("werr", e1, 1);
		apb(0, 12'h0E0, 0, 0);
		chk("rerr", e1, 1);
		chk("rzero", r, 0);
		for (i = 0; i < 5; i++) rd(i);
		outs;
		$display("refusal test done");
		@(posedge clk);
		nrst <= 0;
		repeat (2) @(posedge clk);
		nrst <= 1;
		mdl = '{default: 0};
		for (i = 0; i < 5; i++) rd(i);
		outs;
		$display("second reset test done");
		tally_and_finish;
	end
endmodule // adcrb_bank_test
`default_nettype wire
